// [logic/week_alarm_timer.sv]
// Function
// RULE_01: Held outputs are firmware-set output pins that keep level on battery alone.
// RULE_02: Pin with held-output function selected reads one on its input register.
// RULE_03: Registers at base plus offset, four-byte steps from 00h to 24h.
// RULE_04: Control bit six enables wake output; clear disables and holds it reset.
// RULE_05: Wake enable also gates week wake decoding; clear means no decode.
// RULE_06: Control bit zero starts/stops counter and prescaler; resets to one.
// RULE_07: Run clear holds the seconds count; set again resumes from it.
// RULE_08: Run clear forces prescaler to zero and selects lowest power state.
// RULE_09: Seconds count sits in bits 27:0 and increments once per second.
// RULE_10: Seconds counter write may take up to one second to take effect.
// RULE_11: Seconds counter reads return the live value.
// RULE_12: Counter and compare accesses complete whatever the run bit state.
// RULE_13: Alarm interrupt and wake event while count is at or above compare.
// RULE_14: Prescaler register is read-only, bits 14:0 give the live value.
// RULE_15: Prescaler counts at 32.768 kHz, wrap from 7FFFh gives one-hertz tick.
// RULE_16: Seconds advance on prescaler step from zero to one, not the wrap.
// RULE_17: Writes finish within two slow ticks; reads answer in one bus cycle.
// RULE_18: Reserved bits read zero and ignore writes.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module week_alarm_timer (
    // Clock and battery-domain reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // Main-rail reset, for held outputs whose reset bit is set
    input  wire logic        i_main_rst,
    // Slow time base: one-cycle pulse per 32.768 kHz period
    input  wire logic        i_tick_32k,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Events
    output logic             o_alarm_irq,
    output logic             o_wake_event,
    output logic             o_wake_decode,
    output logic             o_low_power,
    // Battery-held output pins
    output logic      [5:0]  o_held_out,
    output logic      [5:0]  o_held_select,
    // General purpose input path through the shared pins
    input  wire logic [5:0]  i_pin_in,
    output logic      [5:0]  o_pin_in_read
);

    prescaler_if ps ();

    logic        run_q;
    logic        wake_en_q;
    logic [27:0] sec_q;
    logic [27:0] sec_load_q;
    logic        sec_pend_q;
    logic [27:0] cmp_q;
    logic [5:0]  held_data_q;
    logic [5:0]  held_power_q;
    logic [5:0]  held_reset_q;
    logic        alarm_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    logic        wr_ctrl;
    logic        wr_sec;
    logic        wr_cmp;
    logic        wr_data;
    logic        wr_power;
    logic        wr_reset;

    // Decode of full byte address keeps misaligned accesses off every register
    assign wr_ctrl  = i_wr && (i_addr == week_timer_pkg::OFF_TIMER_CONTROL);   // see RULE_03
    assign wr_sec   = i_wr && (i_addr == week_timer_pkg::OFF_SECONDS_COUNTER); // see RULE_03
    assign wr_cmp   = i_wr && (i_addr == week_timer_pkg::OFF_ALARM_COMPARE);   // see RULE_03
    assign wr_data  = i_wr && (i_addr == week_timer_pkg::OFF_HELD_OUTPUT_DATA);
    assign wr_power = i_wr && (i_addr == week_timer_pkg::OFF_HELD_OUTPUT_POWER);
    assign wr_reset = i_wr && (i_addr == week_timer_pkg::OFF_HELD_OUTPUT_RESET);

    // Control register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            run_q     <= week_timer_pkg::RUN_RESET;  // see RULE_06
            wake_en_q <= week_timer_pkg::WAKE_RESET;
        end else if (wr_ctrl) begin
            run_q     <= i_wdata[week_timer_pkg::CTRL_RUN_BIT];  // see RULE_06
            wake_en_q <= i_wdata[week_timer_pkg::CTRL_WAKE_BIT]; // see RULE_04
        end
    end

    // Prescaler link
    assign ps.run  = run_q;      // see RULE_06
    assign ps.tick = i_tick_32k;

    week_prescaler u_prescaler (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .ps      (ps)
    );

    // A write is parked until the next slow tick, as the counting logic
    // lives on that time base; this bounds the latency to one slow period.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sec_pend_q <= 1'b0;
            sec_load_q <= week_timer_pkg::SEC_RESET;
        end else if (wr_sec) begin
            sec_pend_q <= 1'b1;                            // see RULE_12
            sec_load_q <= i_wdata[week_timer_pkg::SEC_W-1:0]; // see RULE_18
        end else if (i_tick_32k) begin
            sec_pend_q <= 1'b0;                            // see RULE_17
        end
    end

    // Seconds counter; a pending load beats a same-tick advance
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sec_q <= week_timer_pkg::SEC_RESET;
        end else if (sec_pend_q && i_tick_32k) begin
            sec_q <= sec_load_q;          // see RULE_10
        end else if (ps.step) begin
            sec_q <= sec_q + 28'h0000001; // see RULE_09 see RULE_16
        end
        // Otherwise held, including while stopped   see RULE_07
    end

    // Compare register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cmp_q <= week_timer_pkg::CMP_RESET;
        end else if (wr_cmp) begin
            cmp_q <= i_wdata[week_timer_pkg::SEC_W-1:0]; // see RULE_12
        end
    end

    // Alarm level, registered to keep the wide compare off the pin path
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            alarm_q <= 1'b0;
        end else begin
            alarm_q <= (sec_q >= cmp_q); // see RULE_13
        end
    end

    assign o_alarm_irq   = alarm_q;                // see RULE_13
    assign o_wake_event  = alarm_q && wake_en_q;   // see RULE_04
    assign o_wake_decode = alarm_q && wake_en_q;   // see RULE_05
    assign o_low_power   = !run_q;                 // see RULE_08

    // Held outputs; battery reset clears them, main-rail reset clears only data bits whose reset bit is set
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            held_power_q <= week_timer_pkg::HELD_RESET;
            held_reset_q <= week_timer_pkg::HELD_RESET;
        end else begin
            if (wr_power) begin
                held_power_q <= i_wdata[week_timer_pkg::HELD_W-1:0];
            end
            if (wr_reset) begin
                held_reset_q <= i_wdata[week_timer_pkg::HELD_W-1:0];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            held_data_q <= week_timer_pkg::HELD_RESET;
        end else if (wr_data) begin
            held_data_q <= i_wdata[week_timer_pkg::HELD_W-1:0]; // see RULE_01
        end else if (i_main_rst) begin
            held_data_q <= held_data_q & ~held_reset_q;         // see RULE_01
        end
    end

    assign o_held_out    = held_data_q;                   // see RULE_01
    assign o_held_select = held_power_q;
    assign o_pin_in_read = i_pin_in | held_power_q;       // see RULE_02

    // Read mux; unlisted and not-held offsets answer zero
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (i_addr)
            week_timer_pkg::OFF_TIMER_CONTROL: begin
                rdata_d[week_timer_pkg::CTRL_RUN_BIT]  = run_q;
                rdata_d[week_timer_pkg::CTRL_WAKE_BIT] = wake_en_q; // see RULE_18
            end
            week_timer_pkg::OFF_SECONDS_COUNTER: begin
                rdata_d[week_timer_pkg::SEC_W-1:0] = sec_q;         // see RULE_11
            end
            week_timer_pkg::OFF_ALARM_COMPARE: begin
                rdata_d[week_timer_pkg::SEC_W-1:0] = cmp_q;
            end
            week_timer_pkg::OFF_PRESCALER_VALUE: begin
                rdata_d[week_timer_pkg::PRESC_W-1:0] = ps.value;    // see RULE_14
            end
            week_timer_pkg::OFF_HELD_OUTPUT_DATA: begin
                rdata_d[week_timer_pkg::HELD_W-1:0] = held_data_q;
            end
            week_timer_pkg::OFF_HELD_OUTPUT_POWER: begin
                rdata_d[week_timer_pkg::HELD_W-1:0] = held_power_q;
            end
            week_timer_pkg::OFF_HELD_OUTPUT_RESET: begin
                rdata_d[week_timer_pkg::HELD_W-1:0] = held_reset_q;
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_q <= 32'h00000000;
        end else if (i_rd) begin
            rdata_q <= rdata_d; // see RULE_17
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign o_rdata = rdata_q;

endmodule

// [logic/week_timer_pkg.sv]
package week_timer_pkg;

    // Register offsets, byte addresses
    localparam logic [7:0] OFF_TIMER_CONTROL        = 8'h00;
    localparam logic [7:0] OFF_SECONDS_COUNTER      = 8'h04;
    localparam logic [7:0] OFF_ALARM_COMPARE        = 8'h08;
    localparam logic [7:0] OFF_PRESCALER_VALUE      = 8'h0C;
    localparam logic [7:0] OFF_FRACTION_INT_SELECT  = 8'h10;
    localparam logic [7:0] OFF_SHORT_TIMER_CONTROL  = 8'h14;
    localparam logic [7:0] OFF_SHORT_TIMER_COUNTER  = 8'h18;
    localparam logic [7:0] OFF_HELD_OUTPUT_DATA     = 8'h1C;
    localparam logic [7:0] OFF_HELD_OUTPUT_POWER    = 8'h20;
    localparam logic [7:0] OFF_HELD_OUTPUT_RESET    = 8'h24;

    // Field layout
    localparam int          CTRL_RUN_BIT  = 0;
    localparam int          CTRL_WAKE_BIT = 6;
    localparam int          SEC_W         = 28;
    localparam int          PRESC_W       = 15;
    localparam int          HELD_W        = 6;

    // Reset values
    localparam logic        RUN_RESET     = 1'b1;
    localparam logic        WAKE_RESET    = 1'b0;
    localparam logic [27:0] SEC_RESET     = 28'h0000000;
    localparam logic [27:0] CMP_RESET     = 28'h0FFFFFF;
    localparam logic [14:0] PRESC_RESET   = 15'h0001;
    localparam logic [14:0] PRESC_ZERO    = 15'h0000;
    localparam logic [14:0] PRESC_MAX     = 15'h7FFF;
    localparam logic [5:0]  HELD_RESET    = 6'h00;

    // Timing: slow tick rate against the bus clock
    localparam int          CLK_HZ        = 125000000;
    localparam int          SLOW_HZ       = 32768;
    localparam int          WRITE_TICKS   = 2;
    localparam int          WRITE_CYCLES  = (WRITE_TICKS * (CLK_HZ / SLOW_HZ));

endpackage

// [logic/prescaler_if.sv]
`timescale 1ns/100ps
interface prescaler_if;
    logic        run;
    logic        tick;
    logic [14:0] value;
    logic        wrap;
    logic        step;

    modport owner (output run, output tick, input value, input wrap, input step);
    modport counter (input run, input tick, output value, output wrap, output step);
endinterface

// [logic/week_prescaler.sv]
`timescale 1ns/100ps
module week_prescaler (
    // Clock and reset
    input  wire logic    i_clock,
    input  wire logic    i_rst,
    // Link to the timer core
    prescaler_if.counter ps
);

    logic [14:0] value_q;

    // Forced to zero while stopped; free-running 15-bit wrap otherwise
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            value_q <= week_timer_pkg::PRESC_RESET;
        end else if (!ps.run) begin
            value_q <= week_timer_pkg::PRESC_ZERO; // see RULE_08
        end else if (ps.tick) begin
            value_q <= value_q + 15'h0001; // see RULE_15
        end
    end

    assign ps.value = value_q;
    // One-hertz tick at the wrap from the top value
    assign ps.wrap  = ps.run && ps.tick && (value_q == week_timer_pkg::PRESC_MAX); // see RULE_15
    // Seconds advance one slow tick later, on the step from zero to one
    assign ps.step  = ps.run && ps.tick && (value_q == week_timer_pkg::PRESC_ZERO); // see RULE_16

endmodule

// [dv/week_alarm_timer_sva.sv]
`timescale 1ns/100ps
module week_alarm_timer_chk (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_main_rst,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        o_alarm_irq,
    input wire logic        o_wake_event,
    input wire logic        o_wake_decode,
    input wire logic        o_low_power,
    input wire logic [5:0]  o_held_out,
    input wire logic [5:0]  o_held_select,
    input wire logic [5:0]  i_pin_in,
    input wire logic [5:0]  o_pin_in_read
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence ctrl_wr;
        i_wr && i_addr == 8'h00;
    endsequence
    // Idle bus must read zero so stale data never leaks
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero when idle");
    run_power_a: assert property (ctrl_wr |=> o_low_power == !$past(i_wdata[0]))
        else $error("low power does not follow run bit");
    power_hold_a: assert property (!(i_wr && i_addr == 8'h00) |=> $stable(o_low_power))
        else $error("low power changed without control write");
    wake_off_a: assert property (ctrl_wr ##0 !i_wdata[6] |=> !o_wake_event && !o_wake_decode)
        else $error("wake active after enable cleared");
    wake_gate_a: assert property ((o_wake_event || o_wake_decode) |-> o_alarm_irq)
        else $error("wake without alarm");
    pin_read_a: assert property (o_pin_in_read == (i_pin_in | o_held_select))
        else $error("pin input read wrong");
    held_data_a: assert property (i_wr && i_addr == 8'h1C && !i_main_rst |=> o_held_out == $past(i_wdata[5:0]))
        else $error("held output not written");
    presc_rsvd_a: assert property (i_rd && i_addr == 8'h0C |=> o_rdata[31:15] == 17'h0)
        else $error("prescaler reserved bits set");
    unmapped_rd_a: assert property (i_rd && (i_addr > 8'h24 || i_addr == 8'h10) |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind week_alarm_timer week_alarm_timer_chk chk_i (.i_clock, .i_rst, .i_main_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_alarm_irq, .o_wake_event, .o_wake_decode, .o_low_power, .o_held_out, .o_held_select, .i_pin_in,
    .o_pin_in_read);

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    logic        i_clock, i_rst, i_main_rst, i_tick_32k, i_wr, i_rd;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic [5:0]  i_pin_in;
    logic [31:0] o_rdata;
    logic        o_alarm_irq, o_wake_event, o_wake_decode, o_low_power;
    logic [5:0]  o_held_out, o_held_select, o_pin_in_read;
    int          failures;
    int          cmp_count;

    week_alarm_timer uut (.i_clock, .i_rst, .i_main_rst, .i_tick_32k, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_alarm_irq, .o_wake_event, .o_wake_decode, .o_low_power, .o_held_out, .o_held_select, .i_pin_in,
        .o_pin_in_read);

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk("rdata", o_rdata, e);
    endtask
    // Tick every other cycle keeps a full wrap near 65k cycles
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_clock);
            i_tick_32k <= 1'b1;
            @(posedge i_clock);
            i_tick_32k <= 1'b0;
        end
    endtask
    task automatic t_reset;
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h00FFFFFF);
        rd(8'h0C, 32'h1);
        rd(8'h10, 32'h0);
        rd(8'h28, 32'h0);
        chk("lowpw", o_low_power, 1'b0);
    endtask
    task automatic t_access;
        wr(8'h0C, 32'h00005555);
        rd(8'h0C, 32'h1);
        wr(8'h08, 32'hFFFFFFFF);
        rd(8'h08, 32'h0FFFFFFF);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'h41);
    endtask
    task automatic t_stop;
        wr(8'h00, 32'h40);
        chk("lowpw", o_low_power, 1'b1);
        tick(3);
        rd(8'h0C, 32'h0);
        rd(8'h04, 32'h0);
        wr(8'h08, 32'h00000005);
        rd(8'h08, 32'h00000005);
    endtask
    task automatic t_count;
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h41);
        tick(1);
        rd(8'h04, 32'h1);
        rd(8'h0C, 32'h1);
        tick(32767);
        rd(8'h0C, 32'h0);
        rd(8'h04, 32'h1);
        chk("alarm", o_alarm_irq, 1'b0);
        tick(1);
        rd(8'h04, 32'h2);
        chk("alarm", o_alarm_irq, 1'b1);
        chk("wake", o_wake_event, 1'b1);
        chk("decode", o_wake_decode, 1'b1);
        wr(8'h00, 32'h01);
        chk("wake", o_wake_event, 1'b0);
        chk("alarm", o_alarm_irq, 1'b1);
    endtask
    task automatic t_load;
        wr(8'h04, 32'hF0ABCDEF);
        tick(1);
        rd(8'h04, 32'h00ABCDEF);
        chk("alarm", o_alarm_irq, 1'b1);
        wr(8'h00, 32'h00000000);
        tick(2);
        rd(8'h04, 32'h00ABCDEF);
        wr(8'h04, 32'h00000123);
        tick(1);
        rd(8'h04, 32'h00000123);
        wr(8'h00, 32'h00000001);
        tick(1);
        rd(8'h04, 32'h00000124);
    endtask
    task automatic t_held;
        @(posedge i_clock);
        i_pin_in <= 6'h10;
        wr(8'h1C, 32'h3F);
        wr(8'h20, 32'h05);
        wr(8'h24, 32'h01);
        chk("held", o_held_out, 6'h3F);
        chk("pin", o_pin_in_read, 6'h15);
        chk("select", o_held_select, 6'h05);
        @(posedge i_clock);
        i_main_rst <= 1'b1;
        @(posedge i_clock);
        i_main_rst <= 1'b0;
        @(posedge i_clock);
        #1 chk("held", o_held_out, 6'h3E);
    endtask
    task automatic complete_run;
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    initial begin
        {i_rst, i_main_rst, i_tick_32k, i_wr, i_rd} = 5'h10;
        {i_addr, i_wdata, i_pin_in} = '0;
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset();
        t_access();
        t_stop();
        t_count();
        t_load();
        t_held();
        complete_run();
    end
    initial begin
        repeat (80000) @(posedge i_clock);
        failures++;
        complete_run();
    end
endmodule
